/* File: dls_pkg.sv */
`default_nettype none
// ==========================================================================
// Shared constants for the display list sequencer.
// ==========================================================================
package dls_pkg;

	// ======================================================================
	// Register port offsets (word index on the plain register port).
	// ======================================================================
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h1;
	localparam logic [3:0] REG_PROG_COUNTER = 4'h2;
	localparam logic [3:0] REG_BANK = 4'h3;
	localparam logic [3:0] REG_GENERAL0 = 4'h4;
	localparam logic [3:0] REG_GLYPH_BASE = 4'h5;
	localparam logic [3:0] REG_ELLIPSE_X = 4'h6;
	localparam logic [3:0] REG_ELLIPSE_Y = 4'h7;

	// Control register fields and reset values.
	localparam int CTRL_RUN_BIT = 0;
	localparam int CTRL_EXT_BIT = 1;
	localparam logic CTRL_RUN_RESET = 1'b0;
	localparam logic CTRL_EXT_RESET = 1'b0;

	// ======================================================================
	// Instruction encodings.
	// ======================================================================
	// Two-word flow and glyph base opcodes sit in bits 15..6.
	localparam logic [9:0] OP_ABS_BRANCH = 10'h008;
	localparam logic [9:0] OP_REL_BRANCH = 10'h009;
	localparam logic [9:0] OP_COND_BRANCH = 10'h00a;
	localparam logic [9:0] OP_COND_REL_BRANCH = 10'h00b;
	localparam logic [9:0] OP_LOAD_GLYPH_BASE = 10'h027;
	// The short relative branch sits in bits 15..9.
	localparam logic [6:0] OP_SHORT_REL = 7'h05;
	// Ellipse opcodes sit in bits 15..11, operand in bits 10..0.
	localparam logic [4:0] OP_LOAD_ELLIPSE_X = 5'h06;
	localparam logic [4:0] OP_DRAW_ELLIPSE_Y = 5'h07;
	// Single character: bits 15..10, bit 8 is the shift bit.
	localparam logic [5:0] OP_SINGLE_CHAR = 6'h27;
	localparam int TEXT_MARK_HI = 15;
	localparam int TEXT_MARK_LO = 7;
	localparam int CHAR_SHIFT_BIT = 8;

	// ======================================================================
	// Character codes and glyph walking.
	// ======================================================================
	localparam logic [6:0] CODE_NULL = 7'h00;
	localparam logic [6:0] CODE_TO_EXTENDED = 7'h0e;
	localparam logic [6:0] CODE_TO_STANDARD = 7'h0f;
	localparam logic [6:0] CODE_ENTER_DOWNLOAD = 7'h1b;
	localparam logic [6:0] CODE_FIRST_SHOWN = 7'h20;
	localparam int GLYPH_SHIFT = 4;
	localparam int GLYPH_LAST_ROW_BIT = 0;
	localparam logic [4:0] GLYPH_MAX_ROWS = 5'd16;

	// ======================================================================
	// Address arithmetic.
	// ======================================================================
	localparam logic [15:0] WORD_STEP = 16'h0002;
	localparam logic [15:0] EVEN_MASK = 16'hfffe;
	localparam logic [1:0] BANK_RESET = 2'h0;
	localparam logic [15:0] PC_RESET = 16'h0000;

	// ======================================================================
	// Types.
	// ======================================================================
	typedef enum logic [1:0] {SET_STANDARD, SET_EXTENDED, SET_DOWNLOAD} char_set_t;
	typedef enum logic [2:0] {ST_IDLE, ST_FETCH, ST_DECODE, ST_SECOND, ST_BRANCH, ST_INDIRECT, ST_TEXT,
		ST_GLYPH} seq_state_t;

endpackage
`default_nettype wire

/* File: glyph_addr_gen.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Glyph address forming and stepping.
// ==========================================================================
module glyph_addr_gen
	import dls_pkg::*;
(
	// Character and table base.
	input wire logic [6:0] code,
	input wire logic [17:0] base,
	// Walking address and its direction.
	input wire logic [17:0] cur_addr,
	input wire logic walk_down,
	// Results.
	output logic [17:0] start_addr,
	output logic [17:0] next_addr
);

	// Shifted code with its low bit copied into the vacated bits.
	logic [17:0] shifted_code;

	assign shifted_code = {7'h00, code, {GLYPH_SHIFT{code[0]}}};
	assign start_addr = shifted_code | base;

	assign next_addr = walk_down ? (cur_addr - 18'd1) : (cur_addr + 18'd1);

endmodule
`default_nettype wire

/* File: ellipse_regs.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Ellipse axis registers and draw strobe.
// ==========================================================================
module ellipse_regs
	import dls_pkg::*;
(
	// Clock and reset.
	input wire logic clock,
	input wire logic rst_b,
	// Instruction strobes from the decoder.
	input wire logic load_x,
	input wire logic draw_y,
	input wire logic other_instr,
	input wire logic [10:0] operand,
	// Register contents and draw request.
	output logic [10:0] ellipse_x_reg,
	output logic [10:0] ellipse_y_reg,
	output logic ellipse_draw
);

	// Set while the instruction just executed was a load of the X axis.
	logic x_loaded;

	// Tracks whether the draw directly follows an X load; any other
	// instruction in between turns the next draw into a circle.
	always_ff @(posedge clock)
	begin
		if (!rst_b)
			x_loaded <= 1'b0;
		else if (load_x)
			x_loaded <= 1'b1;
		else if (draw_y || other_instr)
			x_loaded <= 1'b0;
	end

	// Axis registers load from bits 10..0 of the instruction.
	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			ellipse_x_reg <= 11'h000;
			ellipse_y_reg <= 11'h000;
		end
		else if (load_x)
			ellipse_x_reg <= operand;
		else if (draw_y)
		begin
			ellipse_y_reg <= operand;
			if (!x_loaded)
				ellipse_x_reg <= operand;
		end
	end

	always_ff @(posedge clock)
	begin
		if (!rst_b)
			ellipse_draw <= 1'b0;
		else
			ellipse_draw <= draw_y;
	end

endmodule
`default_nettype wire

/* File: display_list_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Summary of operation
// - Glyph address: code shifted, LSB-filled, ORed base.
// - Glyph walk steps up if even, down if odd.
// - Rows up to seven pixels, bit0 ends, sixteen rows.
// - Download set: 016 to extended, 017 to standard.
// - Code 033 in text enters download set.
// - Load X writes bits 0-10 to X register.
// - Draw Y writes Y register, then draws ellipse.
// - Draw without prior X load makes a circle.
// - Extended mode gives flow instructions 18-bit addresses.
// - Absolute branch code; first word bits give bank.
// - Bit 15 indirect normally, address bit when extended.
// - Indirect branches fetch target, repeated levels allowed.
// - Relative branch adds increment to advanced counter.
// - Extended relative carry or borrow steps the bank.
// - Short relative adds signed bits 0-8 to counter.
// - Zero short relative increment acts as no-op.
// - Conditional branches taken only if register 0 nonzero.
// ==========================================================================
module display_list_sequencer
	import dls_pkg::*;
(
	// Clock and reset.
	input wire logic clock,
	input wire logic rst_b,
	// Register port.
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// Display list memory.
	output logic mem_req,
	output logic [17:0] mem_addr,
	input wire logic mem_ack,
	input wire logic [15:0] mem_rdata,
	// Characters for the text generator.
	output logic char_valid,
	output logic [6:0] char_code,
	output char_set_t char_set_out,
	// Glyph rows from downloadable tables.
	output logic glyph_row_valid,
	output logic [7:0] glyph_row_data,
	output logic glyph_row_last,
	// Ellipse generator.
	output logic ellipse_draw,
	output logic [10:0] ellipse_x_reg,
	output logic [10:0] ellipse_y_reg,
	// Instructions for other units.
	output logic foreign_valid,
	output logic [15:0] foreign_word
);

	// ======================================================================
	// State.
	// ======================================================================
	seq_state_t state; // Sequencer state.
	logic run; // Software lets the sequencer fetch.
	logic extended_addr_mode; // Bank-extended 18-bit flow addressing.
	logic [15:0] general_reg0; // Condition register for conditional branches.
	logic [15:0] display_prog_counter; // Byte address of the next word.
	logic [1:0] bank_reg; // Address bits 17 and 16.
	logic [15:0] ir; // First word of the current instruction.
	logic [15:0] w2; // Second word or indirect target.
	logic [17:0] glyph_base; // Base of the downloadable glyph table.
	char_set_t char_set; // Character set in force for text.
	logic slot; // Second character of a two-character word.
	logic [17:0] glyph_addr; // Byte address of the glyph row.
	logic glyph_down; // Walk direction, fixed per glyph.
	logic [4:0] glyph_rows; // Rows already delivered for this glyph.

	// ======================================================================
	// Decode.
	// ======================================================================
	logic is_abs, is_rel, is_cond, is_cond_rel, is_glyph_base;
	logic is_short_rel, is_ell_x, is_ell_y, is_char, is_text;
	logic two_chars; // Word carries two characters.
	logic [6:0] cur_code; // Character under treatment.
	logic [7:0] row_byte; // Glyph byte picked from the memory word.
	logic [16:0] rel_sum; // Counter plus increment with carry.
	logic [15:0] short_inc; // Sign-extended short increment.
	logic taken; // Branch condition holds.
	logic [17:0] glyph_start;
	logic [17:0] glyph_next;

	assign is_abs = (ir[15:6] == OP_ABS_BRANCH);
	assign is_rel = (ir[15:6] == OP_REL_BRANCH);
	assign is_cond = (ir[15:6] == OP_COND_BRANCH);
	assign is_cond_rel = (ir[15:6] == OP_COND_REL_BRANCH);
	assign is_glyph_base = (ir[15:6] == OP_LOAD_GLYPH_BASE);
	assign is_short_rel = (ir[15:9] == OP_SHORT_REL);
	assign is_ell_x = (ir[15:11] == OP_LOAD_ELLIPSE_X);
	assign is_ell_y = (ir[15:11] == OP_DRAW_ELLIPSE_Y);
	assign is_char = (ir[15:10] == OP_SINGLE_CHAR) && ir[TEXT_MARK_LO];
	assign is_text = ir[TEXT_MARK_HI] && ir[TEXT_MARK_LO];
	assign two_chars = is_text && !is_char;
	assign cur_code = slot ? ir[14:8] : ir[6:0];
	assign row_byte = glyph_addr[0] ? mem_rdata[15:8] : mem_rdata[7:0];
	assign rel_sum = {1'b0, display_prog_counter} + {1'b0, w2};
	assign short_inc = {{7{ir[8]}}, ir[8:0]};
	assign taken = !(is_cond || is_cond_rel) || (general_reg0 != 16'h0000);

	// Glyph address forming and stepping.
	glyph_addr_gen u_glyph_addr (
		.code(cur_code),
		.base(glyph_base),
		.cur_addr(glyph_addr),
		.walk_down(glyph_down),
		.start_addr(glyph_start),
		.next_addr(glyph_next)
	);

	// Ellipse registers; every decoded word that is not an ellipse
	// instruction breaks the pairing of load and draw.
	ellipse_regs u_ellipse (
		.clock(clock),
		.rst_b(rst_b),
		.load_x((state == ST_DECODE) && is_ell_x),
		.draw_y((state == ST_DECODE) && is_ell_y),
		.other_instr((state == ST_DECODE) && !is_ell_x && !is_ell_y),
		.operand(ir[10:0]),
		.ellipse_x_reg(ellipse_x_reg),
		.ellipse_y_reg(ellipse_y_reg),
		.ellipse_draw(ellipse_draw)
	);

	// ======================================================================
	// Memory request.
	// ======================================================================
	// The request is a level held until the acknowledge; the address is
	// built from registers only, so it is stable while the request stands.
	assign mem_req = (state == ST_FETCH) || (state == ST_SECOND) || (state == ST_INDIRECT) ||
		(state == ST_GLYPH);

	always_comb
	begin
		if (state == ST_INDIRECT)
			mem_addr = {bank_reg, 1'b0, w2[14:1], 1'b0};
		else if (state == ST_GLYPH)
			mem_addr = {glyph_addr[17:1], 1'b0};
		else
			mem_addr = {bank_reg, display_prog_counter & EVEN_MASK};
	end

	// ======================================================================
	// Software registers.
	// ======================================================================
	// Control and condition register writes.
	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			run <= CTRL_RUN_RESET;
			extended_addr_mode <= CTRL_EXT_RESET;
			general_reg0 <= 16'h0000;
		end
		else if (reg_wr)
		begin
			if (reg_addr == REG_CTRL)
			begin
				run <= reg_wdata[CTRL_RUN_BIT];
				extended_addr_mode <= reg_wdata[CTRL_EXT_BIT];
			end
			else if (reg_addr == REG_GENERAL0)
				general_reg0 <= reg_wdata;
		end
	end

	// Read data stand in the cycle after the read strobe only.
	always_ff @(posedge clock)
	begin
		if (!rst_b)
			reg_rdata <= 16'h0000;
		else if (!reg_rd)
			reg_rdata <= 16'h0000;
		else if (reg_addr == REG_CTRL)
			reg_rdata <= {14'h0000, extended_addr_mode, run};
		else if (reg_addr == REG_STATUS)
			reg_rdata <= {13'h0000, char_set, (state != ST_IDLE)};
		else if (reg_addr == REG_PROG_COUNTER)
			reg_rdata <= display_prog_counter;
		else if (reg_addr == REG_BANK)
			reg_rdata <= {14'h0000, bank_reg};
		else if (reg_addr == REG_GENERAL0)
			reg_rdata <= general_reg0;
		else if (reg_addr == REG_GLYPH_BASE)
			reg_rdata <= glyph_base[15:0];
		else if (reg_addr == REG_ELLIPSE_X)
			reg_rdata <= {5'h00, ellipse_x_reg};
		else if (reg_addr == REG_ELLIPSE_Y)
			reg_rdata <= {5'h00, ellipse_y_reg};
		else
			reg_rdata <= 16'h0000;
	end

	// ======================================================================
	// Sequencer.
	// ======================================================================
	// One process owns the counter, bank and walking state, so software
	// loads of the counter and bank are taken only while idle.
	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			state <= ST_IDLE;
			display_prog_counter <= PC_RESET;
			bank_reg <= BANK_RESET;
			ir <= 16'h0000;
			w2 <= 16'h0000;
			glyph_base <= 18'h00000;
			char_set <= SET_STANDARD;
			slot <= 1'b0;
			glyph_addr <= 18'h00000;
			glyph_down <= 1'b0;
			glyph_rows <= 5'd0;
		end
		else
		begin
			case (state)
				ST_IDLE:
				begin
					// Software may place the counter and bank before running.
					if (reg_wr && (reg_addr == REG_PROG_COUNTER))
						display_prog_counter <= reg_wdata & EVEN_MASK;
					else if (reg_wr && (reg_addr == REG_BANK))
						bank_reg <= reg_wdata[1:0];
					else if (run)
						state <= ST_FETCH;
				end
				ST_FETCH:
				begin
					if (mem_ack)
					begin
						ir <= mem_rdata;
						display_prog_counter <= display_prog_counter + WORD_STEP;
						slot <= 1'b0;
						state <= ST_DECODE;
					end
				end
				ST_DECODE:
				begin
					if (is_abs || is_rel || is_cond || is_cond_rel || is_glyph_base)
						state <= ST_SECOND;
					else if (is_short_rel)
					begin
						display_prog_counter <= (display_prog_counter + short_inc) & EVEN_MASK;
						state <= ST_IDLE;
					end
					else if (is_text)
						state <= ST_TEXT;
					else
						state <= ST_IDLE;
				end
				ST_SECOND:
				begin
					if (mem_ack)
					begin
						w2 <= mem_rdata;
						display_prog_counter <= display_prog_counter + WORD_STEP;
						if (is_glyph_base)
						begin
							// The table stays in the bank current at load time.
							glyph_base <= {bank_reg, mem_rdata};
							state <= ST_IDLE;
						end
						else
							state <= ST_BRANCH;
					end
				end
				ST_BRANCH:
				begin
					if (!taken)
						state <= ST_IDLE;
					else if (is_rel || is_cond_rel)
					begin
						display_prog_counter <= rel_sum[15:0] & EVEN_MASK;
						if (extended_addr_mode && rel_sum[16] && !w2[15])
							bank_reg <= bank_reg + 2'd1;
						else if (extended_addr_mode && !rel_sum[16] && w2[15])
							bank_reg <= bank_reg - 2'd1;
						state <= ST_IDLE;
					end
					else if (extended_addr_mode)
					begin
						bank_reg <= ir[1:0];
						display_prog_counter <= w2 & EVEN_MASK;
						state <= ST_IDLE;
					end
					else if (w2[15])
						state <= ST_INDIRECT;
					else
					begin
						display_prog_counter <= {1'b0, w2[14:1], 1'b0};
						state <= ST_IDLE;
					end
				end
				ST_INDIRECT:
				begin
					if (mem_ack)
					begin
						w2 <= mem_rdata;
						state <= ST_BRANCH;
					end
				end
				ST_TEXT:
				begin
					if (char_set == SET_DOWNLOAD)
					begin
						if (cur_code == CODE_TO_EXTENDED)
							char_set <= SET_EXTENDED;
						else if (cur_code == CODE_TO_STANDARD)
							char_set <= SET_STANDARD;
						else if (cur_code >= CODE_FIRST_SHOWN)
						begin
							glyph_addr <= glyph_start;
							glyph_down <= glyph_start[0];
							glyph_rows <= 5'd0;
						end
					end
					else if (cur_code == CODE_ENTER_DOWNLOAD)
						char_set <= SET_DOWNLOAD;
					// Glyph walk, second character or done.
					if ((char_set == SET_DOWNLOAD) && (cur_code >= CODE_FIRST_SHOWN))
						state <= ST_GLYPH;
					else if (two_chars && !slot)
						slot <= 1'b1;
					else
						state <= ST_IDLE;
				end
				ST_GLYPH:
				begin
					if (mem_ack)
					begin
						glyph_rows <= glyph_rows + 5'd1;
						glyph_addr <= glyph_next;
						if (row_byte[GLYPH_LAST_ROW_BIT] || (glyph_rows == GLYPH_MAX_ROWS - 5'd1))
						begin
							if (two_chars && !slot)
							begin
								slot <= 1'b1;
								state <= ST_TEXT;
							end
							else
								state <= ST_IDLE;
						end
					end
				end
				default:
					state <= ST_IDLE;
			endcase
		end
	end

	// ======================================================================
	// Outputs to neighbouring units.
	// ======================================================================
	// Characters outside the download set go to the text generator; a
	// single character's shift bit picks its set for that character only.
	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			char_valid <= 1'b0;
			char_code <= 7'h00;
			char_set_out <= SET_STANDARD;
		end
		else
		begin
			char_valid <= (state == ST_TEXT) && (char_set != SET_DOWNLOAD) &&
				(cur_code != CODE_ENTER_DOWNLOAD);
			if (state == ST_TEXT)
			begin
				char_code <= cur_code;
				if (is_char)
					char_set_out <= ir[CHAR_SHIFT_BIT] ? SET_STANDARD : SET_EXTENDED;
				else
					char_set_out <= char_set;
			end
		end
	end

	// Glyph rows leave one per memory answer; there is no buffer, so the
	// vector side must take a row in the cycle it appears.
	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			glyph_row_valid <= 1'b0;
			glyph_row_data <= 8'h00;
			glyph_row_last <= 1'b0;
		end
		else
		begin
			glyph_row_valid <= (state == ST_GLYPH) && mem_ack;
			if ((state == ST_GLYPH) && mem_ack)
			begin
				glyph_row_data <= row_byte;
				glyph_row_last <= row_byte[GLYPH_LAST_ROW_BIT] || (glyph_rows == GLYPH_MAX_ROWS - 5'd1);
			end
		end
	end

	// Words this block does not execute are handed on for other units.
	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			foreign_valid <= 1'b0;
			foreign_word <= 16'h0000;
		end
		else
		begin
			foreign_valid <= (state == ST_DECODE) && !(is_abs || is_rel || is_cond || is_cond_rel ||
				is_glyph_base || is_short_rel || is_ell_x || is_ell_y || is_text);
			if (state == ST_DECODE)
				foreign_word <= ir;
		end
	end

endmodule
`default_nettype wire

/* File: dls_memory_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Display list memory answering one request at a time.
module dls_memory_model
(
	// Clock and reset.
	input wire logic clock,
	input wire logic rst_b,
	// Request and answer.
	input wire logic mem_req,
	input wire logic [17:0] mem_addr,
	output logic mem_ack,
	output logic [15:0] mem_rdata
);
	// Word store, indexed by byte address over two.
	logic [15:0] mem [0:131071];
	// Idle cycles still owed before the next answer.
	logic [1:0] delay;
	// Answers come promptly or late; outside an answer the data toggle, so a stale word cannot pass.
	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			mem_ack <= 1'b0;
			mem_rdata <= 16'h0000;
			delay <= 2'h0;
		end
		else if (mem_req && !mem_ack && delay == 2'h0)
		begin
			mem_ack <= 1'b1;
			mem_rdata <= mem[mem_addr[17:1]];
			delay <= 2'($urandom % 3);
		end
		else
		begin
			mem_ack <= 1'b0;
			mem_rdata <= ~mem_rdata;
			if (delay != 2'h0)
				delay <= delay - 2'h1;
		end
	end
endmodule
`default_nettype wire

/* File: display_list_sequencer_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Port checks for the sequencer.
module display_list_sequencer_assertions
(
	// Clock and reset.
	input wire logic clock,
	input wire logic rst_b,
	// Watched ports.
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic mem_req,
	input wire logic [17:0] mem_addr,
	input wire logic mem_ack,
	input wire logic [15:0] mem_rdata,
	input wire logic glyph_row_valid,
	input wire logic [7:0] glyph_row_data,
	input wire logic glyph_row_last,
	input wire logic ellipse_draw,
	input wire logic [10:0] ellipse_y_reg
);
	default clocking @(posedge clock);
	endclocking
	default disable iff (!rst_b);
	// A request still waiting for its answer.
	sequence s_pending;
		mem_req && !mem_ack;
	endsequence
	// A word answered two cycles earlier.
	sequence s_fetched2;
		$past(mem_ack, 2);
	endsequence
	a_addr_even: assert property (mem_req |-> mem_addr[0] == 1'b0)
		else $error("Fetch address is odd.");
	a_req_holds: assert property (s_pending |=> mem_req && $stable(mem_addr))
		else $error("Request moved before its answer.");
	a_row_follows: assert property (glyph_row_valid |-> $past(mem_ack))
		else $error("Glyph row without a fetch.");
	a_row_last: assert property (glyph_row_valid && glyph_row_data[0] |-> glyph_row_last)
		else $error("Final row not flagged.");
	a_draw_loads: assert property (ellipse_draw |-> s_fetched2 ##0 ellipse_y_reg == 11'($past(mem_rdata, 2)))
		else $error("Ellipse Y not taken from the draw word.");
	a_draw_pulse: assert property (ellipse_draw |=> !ellipse_draw)
		else $error("Draw strobe too long.");
	a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
		else $error("Read data outside its cycle.");
	a_reset_idle: assert property (disable iff (1'b0) !rst_b |=> !mem_req && !ellipse_draw && !glyph_row_valid)
		else $error("Activity during reset.");
endmodule
bind display_list_sequencer display_list_sequencer_assertions chk_u (.clock, .rst_b, .reg_rd, .reg_rdata, .mem_req,
	.mem_addr, .mem_ack, .mem_rdata, .glyph_row_valid, .glyph_row_data, .glyph_row_last, .ellipse_draw, .ellipse_y_reg);
`default_nettype wire

/* File: tb_display_list_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Self-checking bench: runs display lists and compares each result.
module tb_display_list_sequencer
	import dls_pkg::*;
;
	logic clock = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata, mem_rdata, rd_val;
	logic [17:0] mem_addr;
	logic mem_req, mem_ack, glyph_row_valid, glyph_row_last, ellipse_draw, char_valid;
	logic [6:0] char_code;
	char_set_t char_set_out;
	logic [7:0] glyph_row_data, row;
	logic [10:0] ellipse_x_reg, ellipse_y_reg, r1, r2, r3;
	int err_count = 0, tests_run = 0, cycles = 0, g, i;
	// Expected ellipse loads, glyph rows and shown characters, in order.
	logic [31:0] exp_e[$], exp_r[$], exp_c[$];
	display_list_sequencer dut_u (.clock, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .mem_req,
		.mem_addr, .mem_ack, .mem_rdata, .char_valid, .char_code, .char_set_out, .glyph_row_valid,
		.glyph_row_data, .glyph_row_last, .ellipse_draw, .ellipse_x_reg, .ellipse_y_reg, .foreign_valid(),
		.foreign_word());
	dls_memory_model mem_u (.clock, .rst_b, .mem_req, .mem_addr, .mem_ack, .mem_rdata);
	initial forever #5 clock = ~clock;
	// ======================================================================
	// Checking and bus tasks.
	task wrap_up;
		if (err_count == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clock);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [3:0] a);
		@(posedge clock);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 rd_val = reg_rdata;
	endtask
	task put(input int a, input logic [15:0] w);
		mem_u.mem[a >> 1] = w;
	endtask
	// Waits for the closing loop, then stops the run and waits for idle.
	task run_to(input logic [15:0] pc);
		rd_val = 'x;
		for (g = 0; g < 300 && rd_val !== pc; g++)
			rd(REG_PROG_COUNTER);
		chk(rd_val, pc);
		wr(REG_CTRL, 16'h0000);
		rd_val = 'x;
		for (g = 0; g < 20 && rd_val[0] !== 1'b0; g++)
			rd(REG_STATUS);
	endtask
	// Hang guard: the whole run needs at most about 1300 cycles.
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			err_count++;
			wrap_up();
		end
	end
	// Every draw strobe, glyph row and character is compared with the next expectation.
	always @(posedge clock)
		if (rst_b)
		begin
			if (ellipse_draw)
				chk({ellipse_x_reg, ellipse_y_reg}, exp_e.size() ? exp_e.pop_front() : 'x);
			if (glyph_row_valid)
				chk({glyph_row_last, glyph_row_data}, exp_r.size() ? exp_r.pop_front() : 'x);
			if (char_valid)
				chk({char_set_out, char_code}, exp_c.size() ? exp_c.pop_front() : 'x);
		end
	// ======================================================================
	// Main sequence.
	initial
	begin
		void'($urandom(32'h298f9fed));
		r1 = 11'($urandom);
		r2 = 11'($urandom);
		r3 = 11'($urandom);
		put('h000, 16'h0a04);
		put('h002, {OP_LOAD_ELLIPSE_X, r3});
		put('h004, {OP_LOAD_ELLIPSE_X, r3});
		put('h006, 16'h0a00);
		put('h008, {OP_DRAW_ELLIPSE_Y, r1});
		put('h00a, {OP_LOAD_ELLIPSE_X, r2});
		put('h00c, {OP_DRAW_ELLIPSE_Y, r3});
		exp_e.push_back({r1, r1});
		exp_e.push_back({r2, r3});
		put('h00e, 16'h0280);
		put('h010, 16'h0100);
		put('h012, 16'h0240);
		put('h014, 16'h0020);
		put('h036, 16'h0200);
		put('h038, 16'h8100);
		put('h100, 16'h8104);
		put('h104, 16'h0040);
		put('h040, 16'h09c0);
		put('h042, 16'h1000);
		put('h044, 16'h9f9b);
		put('h046, 16'h9fcd);
		put('h048, 16'h9f8f);
		put('h04a, 16'h9bc1);
		exp_c.push_back({SET_STANDARD, 7'h41});
		put('h04c, 16'h9f8e);
		put('h04e, 16'h0bfe);
		g = ('h4d << 4) | (('h4d & 1) ? 'hf : 0) | 'h1000;
		for (i = 0; i < 3; i++)
		begin
			row = 8'($urandom) & 8'hfe | 8'(i == 2);
			mem_u.mem[(g - i) >> 1][((g - i) & 1) ? 15 : 7 -: 8] = row;
			exp_r.push_back({i == 2, row});
		end
		put('h00200, 16'h0201);
		put('h00202, 16'h8000);
		put('h18000, 16'h0240);
		put('h18002, 16'h7ffe);
		put('h20002, 16'h0281);
		put('h20004, 16'h0010);
		put('h10010, 16'h0bfe);
		repeat (8) @(posedge clock);
		rst_b <= 1'b1;
		rd(4'hf);
		chk(rd_val, 16'h0000);
		wr(REG_CTRL, 16'h0001);
		run_to(16'h004e);
		chk(exp_e.size() + exp_r.size() + exp_c.size(), 0);
		rd(REG_STATUS);
		chk(rd_val[2:1], 2'd1);
		rd(REG_ELLIPSE_X);
		chk(rd_val, {5'h00, r2});
		wr(REG_PROG_COUNTER, 16'h0200);
		wr(REG_GENERAL0, 16'h0001);
		wr(REG_CTRL, 16'h0003);
		run_to(16'h0010);
		rd(REG_BANK);
		chk(rd_val[1:0], 2'd1);
		wrap_up();
	end
endmodule
`default_nettype wire
